/* File: core/gpio_params.svh */
// register offsets, field positions and reset values of the port block
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

`define ADDR_PORT_B_INPUT_LEVELS  8'h03
`define ADDR_PORT_B_DIRECTION     8'h04
`define ADDR_PORT_B_OUTPUT_LATCH  8'h05
`define ADDR_PORT_C_INPUT_LEVELS  8'h06
`define ADDR_PORT_C_DIRECTION     8'h07
`define ADDR_PORT_C_OUTPUT_LATCH  8'h08
`define ADDR_PORT_D_INPUT_LEVELS  8'h09
`define ADDR_PORT_D_DIRECTION     8'h0A
`define ADDR_PORT_D_OUTPUT_LATCH  8'h0B
`define ADDR_MCU_CONTROL          8'h35

`define PORT_RESET                8'h00
`define PORT_C_IMPL_MASK          8'h7F
`define MCU_CONTROL_RESET         8'h00
`define BIT_GLOBAL_PULLUP_OFF     4
`define BIT_VECTOR_TABLE_SELECT   1
`define BIT_VECTOR_CHANGE_ENABLE  0

`endif

/* File: core/gpio_pkg.sv */
// shared types and pin arithmetic of the port block
package gpio_pkg;

    typedef logic [7:0] byte_t;

    // pull-up is on for an input pin whose latch bit is one, unless globally off
    function automatic byte_t pull_calc(input byte_t dir, input byte_t latch, input logic off);
        pull_calc = ~dir & latch & {8{~off}};
    endfunction : pull_calc

endpackage : gpio_pkg

/* File: core/pin_sync.sv */
// two-flop synchroniser for a byte of asynchronous pin levels
module pin_sync (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] async_in,
    output logic      [7:0] sync_out
);

    logic [7:0] meta_reg;

    // meta_reg is read by the second stage only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 8'h00;
            sync_out <= 8'h00;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : pin_sync

/* File: core/pin_override.sv */
// override mux for one pin: peripheral takes over pull-up, direction, value, input buffer
module pin_override (
    input  wire logic latch_bit,
    input  wire logic dir_bit,
    input  wire logic global_pullup_off,
    input  wire logic inputs_sleep_off,
    input  wire logic pullup_override_enable,
    input  wire logic pullup_override_level,
    input  wire logic direction_override_enable,
    input  wire logic direction_override_level,
    input  wire logic output_value_override_enable,
    input  wire logic output_value_override_level,
    input  wire logic input_buffer_override_enable,
    input  wire logic input_buffer_override_level,
    output logic      pullup_on,
    output logic      drive_out,
    output logic      out_value,
    output logic      input_enable
);

    always_comb begin
        pullup_on    = pullup_override_enable ? pullup_override_level
                                              : (~dir_bit & latch_bit & ~global_pullup_off);
        drive_out    = direction_override_enable ? direction_override_level : dir_bit;
        out_value    = output_value_override_enable ? output_value_override_level : latch_bit;
        input_enable = input_buffer_override_enable ? input_buffer_override_level
                                                    : ~inputs_sleep_off;
    end

endmodule : pin_override

/* File: core/gpio_ports.sv */
// three byte-wide ports with registers and the fourth-port alternate-function overrides
// Summary of operation
// R1 - receiver enabled forces receive pin input
// R2 - forced receive pin pull-up from latch, gated
// R3 - fourth-port bit 0 feeds pin-change source 16
// R4 - global pull-up off kills every pull-up
// R5 - pins 6,5,4 values from compare, sync clock
// R6 - pins 3,1 values from compare B, transmit
// R7 - transmit/receive enables override pull-up and direction
// R8 - pin-change bit and group enable force input buffer
// R9 - external interrupts on pins 3,2 force buffer
// R10 - pins 7..4 keep ordinary pull-up and direction
// R11 - input registers read-only, sampled pin levels
// R12 - latch and direction reset to zero
// R13 - control register bits 4,1,0; others zero
// R14 - transmitter enabled drives transmit pin output
// R15 - inactive overrides leave ordinary register settings
// R16 - writes land next clock, reads return them
`include "gpio_params.svh"

module gpio_ports (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic [7:0] port_b_in,
    output logic      [7:0] port_b_out,
    output logic      [7:0] port_b_oe_n,
    output logic      [7:0] port_b_pullup,
    input  wire logic [7:0] port_c_in,
    output logic      [7:0] port_c_out,
    output logic      [7:0] port_c_oe_n,
    output logic      [7:0] port_c_pullup,
    input  wire logic [7:0] port_d_in,
    output logic      [7:0] port_d_out,
    output logic      [7:0] port_d_oe_n,
    output logic      [7:0] port_d_pullup,
    output logic      [7:0] port_d_input_enable,
    input  wire logic       sleep_inputs_off,
    input  wire logic       receiver_enable,
    input  wire logic       transmitter_enable,
    input  wire logic       tx_data,
    input  wire logic       sync_serial_select,
    input  wire logic       serial_sync_clock,
    input  wire logic       cmp0_a_enable,
    input  wire logic       cmp0_wave_a,
    input  wire logic       cmp0_b_enable,
    input  wire logic       cmp0_wave_b,
    input  wire logic       cmp2_b_enable,
    input  wire logic       cmp2_wave_b,
    input  wire logic       ext_irq_zero_enable,
    input  wire logic       ext_irq_one_enable,
    input  wire logic       pin_change_group2_on,
    input  wire logic [7:0] pin_change_mask_d,
    output logic            pin_change_src_16,
    output logic            vector_table_select,
    output logic            vector_change_enable
);

    gpio_pkg::byte_t port_b_direction_reg;
    gpio_pkg::byte_t port_b_output_latch_reg;
    gpio_pkg::byte_t port_c_direction_reg;
    gpio_pkg::byte_t port_c_output_latch_reg;
    gpio_pkg::byte_t port_d_direction_reg;
    gpio_pkg::byte_t port_d_output_latch_reg;
    gpio_pkg::byte_t mcu_control_reg;
    gpio_pkg::byte_t port_b_input_levels_reg;
    gpio_pkg::byte_t port_c_input_levels_reg;
    gpio_pkg::byte_t port_d_input_levels_reg;
    gpio_pkg::byte_t sync_b;
    gpio_pkg::byte_t sync_c;
    gpio_pkg::byte_t sync_d;
    gpio_pkg::byte_t rdata_next;
    gpio_pkg::byte_t pu_oe;
    gpio_pkg::byte_t pu_ov;
    gpio_pkg::byte_t dd_oe;
    gpio_pkg::byte_t dd_ov;
    gpio_pkg::byte_t pv_oe;
    gpio_pkg::byte_t pv_ov;
    gpio_pkg::byte_t die_oe;
    gpio_pkg::byte_t d_pullup_next;
    gpio_pkg::byte_t d_drive_next;
    gpio_pkg::byte_t d_out_next;
    gpio_pkg::byte_t d_dien_next;
    logic            global_pullup_off;

    assign global_pullup_off = mcu_control_reg[`BIT_GLOBAL_PULLUP_OFF];

    // ---------------- pin synchronisers ----------------
    pin_sync sync_port_b (
        .clk      (clk),
        .rst      (rst),
        .async_in (port_b_in),
        .sync_out (sync_b)
    );

    pin_sync sync_port_c (
        .clk      (clk),
        .rst      (rst),
        .async_in (port_c_in),
        .sync_out (sync_c)
    );

    pin_sync sync_port_d (
        .clk      (clk),
        .rst      (rst),
        .async_in (port_d_in),
        .sync_out (sync_d)
    );

    // ---------------- software registers ----------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_b_direction_reg    <= `PORT_RESET; // R12
            port_b_output_latch_reg <= `PORT_RESET;
        end else if (wr) begin
            if (addr == `ADDR_PORT_B_DIRECTION) begin
                port_b_direction_reg <= wdata; // R16
            end
            if (addr == `ADDR_PORT_B_OUTPUT_LATCH) begin
                port_b_output_latch_reg <= wdata; // R16
            end
        end
    end

    // bit 7 of the third port does not exist: it never stores a one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_c_direction_reg    <= `PORT_RESET; // R12
            port_c_output_latch_reg <= `PORT_RESET;
        end else if (wr) begin
            if (addr == `ADDR_PORT_C_DIRECTION) begin
                port_c_direction_reg <= wdata & `PORT_C_IMPL_MASK; // R12
            end
            if (addr == `ADDR_PORT_C_OUTPUT_LATCH) begin
                port_c_output_latch_reg <= wdata & `PORT_C_IMPL_MASK; // R12
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_d_direction_reg    <= `PORT_RESET; // R12
            port_d_output_latch_reg <= `PORT_RESET;
        end else if (wr) begin
            if (addr == `ADDR_PORT_D_DIRECTION) begin
                port_d_direction_reg <= wdata; // R16
            end
            if (addr == `ADDR_PORT_D_OUTPUT_LATCH) begin
                port_d_output_latch_reg <= wdata; // R16
            end
        end
    end

    // only bits 4, 1 and 0 are implemented
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mcu_control_reg <= `MCU_CONTROL_RESET;
        end else if (wr && addr == `ADDR_MCU_CONTROL) begin
            mcu_control_reg <= 8'h00; // R13
            mcu_control_reg[`BIT_GLOBAL_PULLUP_OFF]    <= wdata[`BIT_GLOBAL_PULLUP_OFF];
            mcu_control_reg[`BIT_VECTOR_TABLE_SELECT]  <= wdata[`BIT_VECTOR_TABLE_SELECT];
            mcu_control_reg[`BIT_VECTOR_CHANGE_ENABLE] <= wdata[`BIT_VECTOR_CHANGE_ENABLE];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vector_table_select  <= 1'b0;
            vector_change_enable <= 1'b0;
        end else begin
            vector_table_select  <= mcu_control_reg[`BIT_VECTOR_TABLE_SELECT];
            vector_change_enable <= mcu_control_reg[`BIT_VECTOR_CHANGE_ENABLE];
        end
    end

    // ---------------- input sampling ----------------
    // a disabled input buffer clamps the sampled level to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_b_input_levels_reg <= 8'h00;
            port_c_input_levels_reg <= 8'h00;
            port_d_input_levels_reg <= 8'h00;
            pin_change_src_16       <= 1'b0;
        end else begin
            port_b_input_levels_reg <= sync_b & {8{~sleep_inputs_off}}; // R11
            port_c_input_levels_reg <= sync_c & {8{~sleep_inputs_off}} & `PORT_C_IMPL_MASK; // R11
            port_d_input_levels_reg <= sync_d & d_dien_next; // R11
            pin_change_src_16       <= sync_d[0] & d_dien_next[0]; // R3
        end
    end

    // ---------------- read port ----------------
    // input registers have no write path at all
    always_comb begin
        rdata_next = 8'h00;
        unique case (addr)
            `ADDR_PORT_B_INPUT_LEVELS: rdata_next = port_b_input_levels_reg; // R11
            `ADDR_PORT_B_DIRECTION:    rdata_next = port_b_direction_reg; // R16
            `ADDR_PORT_B_OUTPUT_LATCH: rdata_next = port_b_output_latch_reg;
            `ADDR_PORT_C_INPUT_LEVELS: rdata_next = port_c_input_levels_reg;
            `ADDR_PORT_C_DIRECTION:    rdata_next = port_c_direction_reg;
            `ADDR_PORT_C_OUTPUT_LATCH: rdata_next = port_c_output_latch_reg;
            `ADDR_PORT_D_INPUT_LEVELS: rdata_next = port_d_input_levels_reg;
            `ADDR_PORT_D_DIRECTION:    rdata_next = port_d_direction_reg;
            `ADDR_PORT_D_OUTPUT_LATCH: rdata_next = port_d_output_latch_reg;
            `ADDR_MCU_CONTROL:         rdata_next = mcu_control_reg; // R13
            default:                   rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd ? rdata_next : 8'h00;
        end
    end

    // ---------------- ports b and c: no overrides ----------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_b_out    <= 8'h00;
            port_b_oe_n   <= 8'hFF;
            port_b_pullup <= 8'h00;
            port_c_out    <= 8'h00;
            port_c_oe_n   <= 8'hFF;
            port_c_pullup <= 8'h00;
        end else begin
            port_b_out    <= port_b_output_latch_reg;
            port_b_oe_n   <= ~port_b_direction_reg;
            port_b_pullup <= gpio_pkg::pull_calc(port_b_direction_reg,
                                                 port_b_output_latch_reg, global_pullup_off); // R4
            port_c_out    <= port_c_output_latch_reg;
            port_c_oe_n   <= ~port_c_direction_reg;
            port_c_pullup <= gpio_pkg::pull_calc(port_c_direction_reg,
                                                 port_c_output_latch_reg, global_pullup_off); // R4
        end
    end

    // ---------------- fourth-port override matrix ----------------
    // pins 7..4 never have pull-up or direction overridden
    always_comb begin
        pu_oe = 8'h00; // R10
        pu_ov = 8'h00;
        dd_oe = 8'h00;
        dd_ov = 8'h00;
        pv_oe = 8'h00;
        pv_ov = 8'h00;
        pu_oe[1] = transmitter_enable; // R7
        pu_ov[1] = 1'b0;
        dd_oe[1] = transmitter_enable; // R14
        dd_ov[1] = 1'b1;
        pu_oe[0] = receiver_enable; // R7
        pu_ov[0] = port_d_output_latch_reg[0] & ~global_pullup_off; // R2
        dd_oe[0] = receiver_enable; // R1
        dd_ov[0] = 1'b0;
        pv_oe[6] = cmp0_a_enable; // R5
        pv_ov[6] = cmp0_wave_a;
        pv_oe[5] = cmp0_b_enable; // R5
        pv_ov[5] = cmp0_wave_b;
        pv_oe[4] = sync_serial_select; // R5
        pv_ov[4] = serial_sync_clock;
        pv_oe[3] = cmp2_b_enable; // R6
        pv_ov[3] = cmp2_wave_b;
        pv_oe[1] = transmitter_enable; // R6
        pv_ov[1] = tx_data;
        die_oe = pin_change_mask_d & {8{pin_change_group2_on}}; // R8
        die_oe[3] = die_oe[3] | ext_irq_one_enable; // R9
        die_oe[2] = die_oe[2] | ext_irq_zero_enable; // R9
    end

    // with every enable low each pin falls back to its registers
    for (genvar k = 0; k < 8; k++) begin : g_pin_d
        pin_override u_ovr (
            .latch_bit                    (port_d_output_latch_reg[k]),
            .dir_bit                      (port_d_direction_reg[k]),
            .global_pullup_off            (global_pullup_off),
            .inputs_sleep_off             (sleep_inputs_off),
            .pullup_override_enable       (pu_oe[k]),
            .pullup_override_level        (pu_ov[k]),
            .direction_override_enable    (dd_oe[k]),
            .direction_override_level     (dd_ov[k]),
            .output_value_override_enable (pv_oe[k]),
            .output_value_override_level  (pv_ov[k]),
            .input_buffer_override_enable (die_oe[k]),
            .input_buffer_override_level  (1'b1),
            .pullup_on                    (d_pullup_next[k]),
            .drive_out                    (d_drive_next[k]),
            .out_value                    (d_out_next[k]),
            .input_enable                 (d_dien_next[k])
        ); // R15
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_d_out          <= 8'h00;
            port_d_oe_n         <= 8'hFF;
            port_d_pullup       <= 8'h00;
            port_d_input_enable <= 8'h00;
        end else begin
            port_d_out          <= d_out_next;
            port_d_oe_n         <= ~d_drive_next;
            port_d_pullup       <= d_pullup_next;
            port_d_input_enable <= d_dien_next;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_rx_forced_input: assert property ( // R1
        receiver_enable |=> port_d_oe_n[0])
        else $error("receive pin driven while receiver enabled");

    a_rx_pullup_latch: assert property ( // R2
        receiver_enable |=> port_d_pullup[0] ==
            ($past(port_d_output_latch_reg[0]) & ~$past(global_pullup_off)))
        else $error("receive pin pull-up not from latch");

    a_pin_change_src_16_level: assert property ( // R3
        $past(d_dien_next[0]) |-> pin_change_src_16 == $past(sync_d[0]))
        else $error("pin-change source 16 not following pin");

    a_global_pullup_off: assert property ( // R4
        $past(global_pullup_off) && !$past(receiver_enable)
            |-> (port_b_pullup | port_c_pullup | port_d_pullup) == 8'h00)
        else $error("pull-up on while globally disabled");

    a_cmp0_value: assert property ( // R5
        cmp0_a_enable ##1 cmp0_a_enable |-> port_d_out[6] == $past(cmp0_wave_a))
        else $error("pin 6 not carrying compare A");

    a_tx_value: assert property ( // R6
        transmitter_enable |=> port_d_out[1] == $past(tx_data))
        else $error("pin 1 not carrying transmit data");

    a_tx_forced_out: assert property ( // R14
        transmitter_enable |=> !port_d_oe_n[1] && !port_d_pullup[1])
        else $error("transmit pin not forced output");

    a_pin_change_buffer: assert property ( // R8
        pin_change_group2_on && pin_change_mask_d[7] |=> port_d_input_enable[7])
        else $error("input buffer off under pin-change enable");

    a_ext_irq_zero_buffer: assert property ( // R9
        ext_irq_zero_enable |=> port_d_input_enable[2])
        else $error("input buffer off under external interrupt");

    a_upper_direction: assert property ( // R10
        ##1 port_d_oe_n[7:4] == ~$past(port_d_direction_reg[7:4]))
        else $error("upper pin direction overridden");

    a_input_read: assert property ( // R11
        rd && addr == `ADDR_PORT_D_INPUT_LEVELS |=> rdata == $past(port_d_input_levels_reg))
        else $error("input register read wrong");

    a_write_read: assert property ( // R16
        wr && addr == `ADDR_PORT_B_DIRECTION ##1 !wr ##1 rd && addr == `ADDR_PORT_B_DIRECTION
            |=> rdata == $past(wdata, 3))
        else $error("direction write not read back");

    a_control_unused: assert property ( // R13
        rd && addr == `ADDR_MCU_CONTROL |=> (rdata & 8'hEC) == 8'h00)
        else $error("unused control bits read nonzero");

    a_port_c_bit7: assert property ( // R12
        port_c_oe_n[7] && !port_c_pullup[7])
        else $error("unimplemented pin active");

endmodule : gpio_ports

/* File: sim/board_model.sv */
// board-side pin model: resolves driven, externally forced and pulled pin levels
module board_model (
    input  wire logic       clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] pin_pullup,
    input  wire logic [7:0] ext_level,
    input  wire logic [7:0] ext_on,
    output logic      [7:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_reg = 8'h55;
    // an open pin has no stable value, so it toggles instead of holding one
    always @(posedge clk) begin
        float_reg <= ~float_reg;
    end
    assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_on & ext_level)
                     | (pin_oe_n & ~ext_on & (pin_pullup | float_reg));
endmodule : board_model

/* File: sim/port_d_override_and_port_regs_bench.sv */
// self-checking bench for the port block: registers, pin levels and overrides
`include "gpio_params.svh"

module port_d_override_and_port_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic [7:0] b_out, b_oe_n, b_pu, c_out, c_oe_n, c_pu, d_out, d_oe_n, d_pu, d_ie;
    logic [7:0] b_pin, c_pin, d_pin;
    logic [7:0] ext_lvl = 8'h00;
    logic [7:0] ext_on = 8'h00;
    logic       sleep_off = 1'b0;
    // 13 rx,12 tx,11 txd,10 sync sel,9 sync clk,8..3 compare enable/wave pairs,
    // 2 irq0,1 irq1,0 pin-change group
    logic [13:0] per = 14'h0000;
    logic [7:0] pc_mask = 8'h00;
    logic       pcs16, vts, vce;
    logic [7:0] rw_addr [6] = '{`ADDR_PORT_B_DIRECTION, `ADDR_PORT_B_OUTPUT_LATCH,
        `ADDR_PORT_C_DIRECTION, `ADDR_PORT_C_OUTPUT_LATCH,
        `ADDR_PORT_D_DIRECTION, `ADDR_PORT_D_OUTPUT_LATCH};
    logic [7:0] wv [6];
    int         n_errors = 0;
    int         tests_run = 0;

    always #5 clk = ~clk;

    gpio_ports dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .port_b_in(b_pin), .port_b_out(b_out), .port_b_oe_n(b_oe_n),
        .port_b_pullup(b_pu), .port_c_in(c_pin), .port_c_out(c_out), .port_c_oe_n(c_oe_n),
        .port_c_pullup(c_pu), .port_d_in(d_pin), .port_d_out(d_out), .port_d_oe_n(d_oe_n),
        .port_d_pullup(d_pu), .port_d_input_enable(d_ie), .sleep_inputs_off(sleep_off),
        .receiver_enable(per[13]), .transmitter_enable(per[12]), .tx_data(per[11]),
        .sync_serial_select(per[10]), .serial_sync_clock(per[9]),
        .cmp0_a_enable(per[8]), .cmp0_wave_a(per[7]), .cmp0_b_enable(per[6]),
        .cmp0_wave_b(per[5]), .cmp2_b_enable(per[4]), .cmp2_wave_b(per[3]),
        .ext_irq_zero_enable(per[2]), .ext_irq_one_enable(per[1]),
        .pin_change_group2_on(per[0]), .pin_change_mask_d(pc_mask),
        .pin_change_src_16(pcs16), .vector_table_select(vts), .vector_change_enable(vce));

    board_model brd_b (.clk(clk), .pin_out(b_out), .pin_oe_n(b_oe_n), .pin_pullup(b_pu),
        .ext_level(ext_lvl), .ext_on(ext_on), .pin_level(b_pin));
    board_model brd_c (.clk(clk), .pin_out(c_out), .pin_oe_n(c_oe_n), .pin_pullup(c_pu),
        .ext_level(ext_lvl), .ext_on(ext_on), .pin_level(c_pin));
    board_model brd_d (.clk(clk), .pin_out(d_out), .pin_oe_n(d_oe_n), .pin_pullup(d_pu),
        .ext_level(ext_lvl), .ext_on(ext_on), .pin_level(d_pin));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask : rd_chk

    task automatic set_per(input logic [13:0] v, input int n);
        @(posedge clk);
        per <= v;
        repeat (n) @(posedge clk);
        #1;
    endtask : set_per

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #200000;
        n_errors++;
        end_of_test();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        set_per(14'h0000, 1);
        chk("b_oe_n", 8'hFF, b_oe_n);
        chk("d_pullup", 8'h00, d_pu);
        for (int i = 0; i < 6; i++) begin
            rd_chk("reset", rw_addr[i], `PORT_RESET);
        end
        rd_chk("mcu", `ADDR_MCU_CONTROL, `MCU_CONTROL_RESET);
        for (int i = 0; i < 6; i++) begin
            wv[i] = (i == 2 || i == 3) ? (8'hDA ^ 8'(i)) & 8'h7F : 8'hDA ^ 8'(i);
            wr_reg(rw_addr[i], 8'hDA ^ 8'(i));
            rd_chk("readback", rw_addr[i], wv[i]);
        end
        set_per(14'h0000, 2);
        chk("b_oe_n", ~wv[0], b_oe_n);
        chk("b_pullup", ~wv[0] & wv[1], b_pu);
        chk("c_oe_n", ~wv[2], c_oe_n);
        chk("c_pullup", ~wv[2] & wv[3] & 8'h7F, c_pu);
        chk("d_pullup", ~wv[4] & wv[5], d_pu);
        chk("b_out", wv[1], b_out);
        chk("c_out", wv[3], c_out);
        wr_reg(`ADDR_MCU_CONTROL, 8'hFF);
        rd_chk("mcu", `ADDR_MCU_CONTROL, 8'h13);
        set_per(14'h0000, 1);
        chk("vector bits", 8'h03, {6'h00, vts, vce});
        chk("b_pullup", 8'h00, b_pu);
        wr_reg(`ADDR_MCU_CONTROL, 8'h00);
        rd_chk("unmapped", 8'h20, 8'h00);
        for (int i = 0; i < 6; i += 2) begin
            wr_reg(rw_addr[i], 8'h00);
        end
        @(posedge clk);
        ext_on <= 8'hFF;
        ext_lvl <= 8'hC3;
        wr_reg(`ADDR_PORT_B_INPUT_LEVELS, 8'h00);
        set_per(14'h0000, 5);
        rd_chk("pin_b", `ADDR_PORT_B_INPUT_LEVELS, 8'hC3);
        rd_chk("pin_c", `ADDR_PORT_C_INPUT_LEVELS, 8'h43);
        rd_chk("pin_d", `ADDR_PORT_D_INPUT_LEVELS, 8'hC3);
        wr_reg(`ADDR_PORT_D_DIRECTION, 8'hFF);
        wr_reg(`ADDR_PORT_D_OUTPUT_LATCH, 8'h00);
        set_per(14'h3FF8, 2);
        chk("d_out", 8'h7A, d_out);
        chk("d_oe_n", 8'h01, d_oe_n);
        wr_reg(`ADDR_PORT_D_OUTPUT_LATCH, 8'hFF);
        set_per(14'h3550, 2);
        chk("d_out", 8'h85, d_out);
        set_per(14'h0000, 2);
        chk("d_out", 8'hFF, d_out);
        chk("d_oe_n", 8'h00, d_oe_n);
        wr_reg(`ADDR_PORT_D_DIRECTION, 8'h00);
        set_per(14'h3550, 2);
        chk("d_pullup", 8'hFD, d_pu);
        chk("d_oe_n", 8'hFD, d_oe_n);
        wr_reg(`ADDR_MCU_CONTROL, 8'h10);
        set_per(14'h3550, 2);
        chk("d_pullup", 8'h00, d_pu);
        @(posedge clk);
        sleep_off <= 1'b1;
        pc_mask <= 8'h81;
        set_per(14'h2000, 2);
        chk("d_in_en", 8'h00, d_ie);
        set_per(14'h2001, 5);
        chk("d_in_en", 8'h81, d_ie);
        chk("src16", 8'h01, {7'h00, pcs16});
        @(posedge clk);
        pc_mask <= 8'h00;
        set_per(14'h2007, 5);
        chk("d_in_en", 8'h0C, d_ie);
        chk("src16", 8'h00, {7'h00, pcs16});
        end_of_test();
    end
endmodule : port_d_override_and_port_regs_bench
